// ---- core/asrc_consts.svh ----
// Timing and field constants for the asynchronous memory controller
`ifndef ASRC_CONSTS_SVH
`define ASRC_CONSTS_SVH
`define ASRC_CLK_NS      100
`define ASRC_ADDR_W      13
`define ASRC_DATA_W      8
// Slow grade figures, in ns; the slow grade also covers the fast grade
`define ASRC_T_ACC_NS    100
`define ASRC_T_OE_NS     50
`define ASRC_T_HZ_NS     35
`define ASRC_T_WP_NS     60
`define ASRC_T_CW_NS     80
`define ASRC_T_AW_NS     80
`define ASRC_T_DW_NS     40
`define ASRC_T_DH_NS     0
`define ASRC_T_AS_NS     0
// Least times round up, longest times round up as waits too
`define ASRC_CYC(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_CNT_W       3
`endif

// ---- core/asrc_pkg.sv ----
// Types for the asynchronous memory controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE,
    ASRC_RD_WAIT,
    ASRC_RD_DONE,
    ASRC_WR_SETUP,
    ASRC_WR_PULSE,
    ASRC_WR_HOLD,
    ASRC_TURN
  } asrc_state_e;
endpackage

// ---- core/asrc_timer.sv ----
// Down counter for strobe interval timing
`timescale 1ns/10ps
`default_nettype none
`include "asrc_consts.svh"
module asrc_timer (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   load_i,
  input  wire logic [`ASRC_CNT_W-1:0] count_i,
  output logic                        done_o
);
  logic [`ASRC_CNT_W-1:0] cnt_q;
  logic [`ASRC_CNT_W-1:0] cnt_d;
  wire                    zero_w = (cnt_q == '0);

  assign cnt_d  = load_i ? count_i :
                  (zero_w ? cnt_q : cnt_q - `ASRC_CNT_W'(1));
  assign done_o = zero_w & ~load_i;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ---- core/asrc_ctrl.sv ----
// Host controller for an asynchronous 8k x 8 static memory
// Overview of operation
// - Write lasts while selected with strobe low.
// - Write strobe held low at least the write pulse time.
// - Selects held active at least select-to-end time before write end.
// - Address stable at least address-to-end time before write end.
// - Address valid no later than write start.
// - Address held stable until write ends.
// - Write data driven at least data setup time before write end.
// - Write data held until the write ends.
// - Controller drives no data while device may still drive.
// - Writes keep the output gate high; the pulse is not stretched.
`timescale 1ns/10ps
`default_nettype none
`include "asrc_consts.svh"
module asrc_ctrl (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    req_i,
  input  wire logic                    req_we_i,
  input  wire logic [`ASRC_ADDR_W-1:0] req_addr_i,
  input  wire logic [`ASRC_DATA_W-1:0] req_wdata_i,
  output logic                         req_ready_o,
  output logic                         rd_valid_o,
  output logic [`ASRC_DATA_W-1:0]      rd_data_o,
  output logic [`ASRC_ADDR_W-1:0]      mem_addr_o,
  output logic                         select_active_low_o,
  output logic                         select_active_high_o,
  output logic                         mem_we_n_o,
  output logic                         mem_oe_n_o,
  input  wire logic [`ASRC_DATA_W-1:0] mem_data_i,
  output logic [`ASRC_DATA_W-1:0]      mem_data_o,
  output logic                         mem_data_oe_o
);
  // Cycle counts derived from the slow-grade figures
  localparam int RD_NS  = (`ASRC_T_ACC_NS > `ASRC_T_OE_NS) ?
                          `ASRC_T_ACC_NS : `ASRC_T_OE_NS;
  localparam int RD_CYC = `ASRC_CYC(RD_NS);
  localparam int WP_A   = `ASRC_T_WP_NS;
  localparam int WP_B   = `ASRC_T_CW_NS;
  localparam int WP_C   = `ASRC_T_AW_NS - `ASRC_T_AS_NS;
  localparam int WP_NS0 = (WP_A > WP_B) ? WP_A : WP_B;
  localparam int WP_NS  = (WP_NS0 > WP_C) ? WP_NS0 : WP_C;
  localparam int WP_CYC = (`ASRC_CYC(WP_NS) < 1) ? 1 : `ASRC_CYC(WP_NS);
  localparam int HZ_CYC = (`ASRC_CYC(`ASRC_T_HZ_NS) < 1) ?
                          1 : `ASRC_CYC(`ASRC_T_HZ_NS);

  asrc_pkg::asrc_state_e st_q;
  asrc_pkg::asrc_state_e st_d;
  logic [`ASRC_ADDR_W-1:0] addr_q;
  logic [`ASRC_DATA_W-1:0] wdat_q;
  logic [`ASRC_DATA_W-1:0] rdat_q;
  logic                    sel_q;
  logic                    we_q;
  logic                    oe_q;
  logic                    doe_q;
  logic                    rdv_q;
  logic                    rdy_q;
  logic                    tmr_load;
  logic [`ASRC_CNT_W-1:0]  tmr_cnt;
  logic                    tmr_done;

  asrc_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_i     (tmr_load),
    .count_i    (tmr_cnt),
    .done_o     (tmr_done)
  );

  wire take_w  = (st_q == asrc_pkg::ASRC_IDLE) & req_i;
  wire start_w = take_w & ~req_we_i;
  wire wr_w    = take_w & req_we_i;

  // Next-state decode
  always_comb begin
    st_d     = st_q;
    tmr_load = 1'b0;
    tmr_cnt  = '0;
    case (st_q)
      asrc_pkg::ASRC_IDLE: begin
        if (start_w) begin
          st_d     = asrc_pkg::ASRC_RD_WAIT;
          tmr_load = 1'b1;
          tmr_cnt  = `ASRC_CNT_W'(RD_CYC);
        end else if (wr_w) begin
          st_d = asrc_pkg::ASRC_WR_SETUP;
        end
      end
      asrc_pkg::ASRC_RD_WAIT: begin
        if (tmr_done) begin
          st_d = asrc_pkg::ASRC_RD_DONE;
        end
      end
      asrc_pkg::ASRC_RD_DONE: begin
        st_d     = asrc_pkg::ASRC_TURN;
        tmr_load = 1'b1;
        tmr_cnt  = `ASRC_CNT_W'(HZ_CYC);
      end
      asrc_pkg::ASRC_WR_SETUP: begin
        st_d     = asrc_pkg::ASRC_WR_PULSE;
        tmr_load = 1'b1;
        tmr_cnt  = `ASRC_CNT_W'(WP_CYC);
      end
      asrc_pkg::ASRC_WR_PULSE: begin
        if (tmr_done) begin
          st_d = asrc_pkg::ASRC_WR_HOLD;
        end
      end
      asrc_pkg::ASRC_WR_HOLD: begin
        st_d = asrc_pkg::ASRC_IDLE;
      end
      asrc_pkg::ASRC_TURN: begin
        if (tmr_done) begin
          st_d = asrc_pkg::ASRC_IDLE;
        end
      end
      default: begin
        st_d = asrc_pkg::ASRC_IDLE;
      end
    endcase
  end

  // Output gate only in reads; strobe low only in the pulse state
  wire in_rd_w  = (st_d == asrc_pkg::ASRC_RD_WAIT) |
                  (st_d == asrc_pkg::ASRC_RD_DONE);
  wire in_wr_w  = (st_d == asrc_pkg::ASRC_WR_SETUP) |
                  (st_d == asrc_pkg::ASRC_WR_PULSE) |
                  (st_d == asrc_pkg::ASRC_WR_HOLD);
  wire pulse_w  = (st_d == asrc_pkg::ASRC_WR_PULSE);
  wire sample_w = (st_q == asrc_pkg::ASRC_RD_WAIT) & tmr_done;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q   <= asrc_pkg::ASRC_IDLE;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      sel_q  <= 1'b0;
      we_q   <= 1'b0;
      oe_q   <= 1'b0;
      doe_q  <= 1'b0;
      rdv_q  <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      // Address and data latched at acceptance, stable through the cycle
      if (take_w) begin
        addr_q <= req_addr_i;
        wdat_q <= req_wdata_i;
      end
      sel_q  <= in_rd_w | in_wr_w;
      we_q   <= pulse_w;
      oe_q   <= in_rd_w;
      doe_q  <= in_wr_w;
      if (sample_w) begin
        rdat_q <= mem_data_i;
      end
      rdv_q  <= sample_w;
      rdy_q  <= (st_d == asrc_pkg::ASRC_IDLE);
    end
  end

  assign mem_addr_o           = addr_q;
  assign select_active_low_o  = ~sel_q;
  assign select_active_high_o = sel_q;
  assign mem_we_n_o           = ~we_q;
  assign mem_oe_n_o           = ~oe_q;
  assign mem_data_o           = wdat_q;
  assign mem_data_oe_o        = doe_q;
  assign rd_data_o            = rdat_q;
  assign rd_valid_o           = rdv_q;
  assign req_ready_o          = rdy_q;

  // Checks on the pins this controller drives
  int unsigned wp_len_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i | ~we_q) begin
      wp_len_q <= 0;
    end else begin
      wp_len_q <= wp_len_q + 1;
    end
  end

  write_pulse_len_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(mem_we_n_o) |-> ($past(wp_len_q) >= WP_CYC))
    else $error("write pulse too short");

  sel_before_end_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(mem_we_n_o) |-> $past(select_active_high_o, 3))
    else $error("select too late before write end");

  addr_before_end_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(mem_we_n_o) |-> ($past(mem_addr_o, 3) == mem_addr_o))
    else $error("address too late before write end");

  strobe_in_select_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !mem_we_n_o |-> (!select_active_low_o && select_active_high_o))
    else $error("write strobe outside select");

  addr_stable_wr_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !mem_we_n_o ##1 1'b1 |-> $stable(mem_addr_o))
    else $error("address moved during write");

  data_before_end_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(mem_we_n_o) |-> $past(mem_data_oe_o) && mem_data_oe_o)
    else $error("write data not held over strobe end");

  no_drive_in_read_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !mem_oe_n_o |-> !mem_data_oe_o)
    else $error("bus driven while gate low");

  turn_gap_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(mem_oe_n_o) |-> !mem_data_oe_o [*2])
    else $error("drive too soon after read");

  read_latency_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $fell(mem_oe_n_o) |-> !rd_valid_o [*2] ##[0:2] rd_valid_o)
    else $error("read data sampled at wrong time");

  setup_before_pulse_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $fell(mem_we_n_o) |-> $past(mem_data_oe_o) && $stable(mem_addr_o))
    else $error("address not set up before strobe");
endmodule
`default_nettype wire

// ---- dv/asrc_mem_model.sv ----
// Behavioural model of the asynchronous static memory
`timescale 1ns/10ps
`default_nettype none
`include "asrc_consts.svh"
module asrc_mem_model #(
  parameter int T_ACC = 95,
  parameter int T_LZ  = 10,
  parameter int T_HZ  = 8
) (
  input  wire logic [`ASRC_ADDR_W-1:0] addr_i,
  input  wire logic                    sel_n_i,
  input  wire logic                    sel_i,
  input  wire logic                    we_n_i,
  input  wire logic                    oe_n_i,
  input  wire logic [`ASRC_DATA_W-1:0] data_i,
  output logic [`ASRC_DATA_W-1:0]      data_o,
  output logic                         data_oe_o,
  output logic                         bad_o
);
  logic [`ASRC_DATA_W-1:0] mem_q [0:(1<<`ASRC_ADDR_W)-1];
  realtime                 t_a = 0, t_d = 0, t_s = 0, t_w = 0;
  wire sel = !sel_n_i && sel_i;
  wire rd  = sel && we_n_i && !oe_n_i;
  wire wr  = sel && !we_n_i;
  initial begin
    data_oe_o = 1'b0;
    bad_o = 1'b0;
  end
  // Release always quicker than turn-on
  always @(rd) data_oe_o <= #(rd ? T_LZ : T_HZ) rd;
  // Old data for a while, then garbage, then the new word
  always @(addr_i or sel or oe_n_i or we_n_i) begin
    data_o <= #10 ~mem_q[addr_i];
    data_o <= #(T_ACC) mem_q[addr_i];
  end
  always @(addr_i) t_a = $realtime;
  always @(data_i) t_d = $realtime;
  always @(posedge sel) t_s = $realtime;
  always @(posedge wr) t_w = $realtime;
  always @(addr_i or data_i) if (wr === 1'b1) bad_o = 1'b1;
  always @(negedge wr) begin
    if (t_w > 0) begin
      mem_q[addr_i] = data_i;
      if ($realtime - t_w < `ASRC_T_WP_NS ||
          $realtime - t_s < `ASRC_T_CW_NS ||
          $realtime - t_a < `ASRC_T_AW_NS ||
          $realtime - t_d < `ASRC_T_DW_NS) begin
        bad_o = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/asrc_ctrl_tb.sv ----
// Self-checking testbench for the asynchronous memory controller
`timescale 1ns/10ps
`default_nettype none
`include "asrc_consts.svh"
module asrc_ctrl_tb;
  logic                    core_clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    req_i = 1'b0;
  logic                    req_we_i = 1'b0;
  logic [`ASRC_ADDR_W-1:0] req_addr_i = '0;
  logic [`ASRC_DATA_W-1:0] req_wdata_i = '0;
  logic                    ready, rd_valid, sel_n, sel, we_n, oe_n;
  logic                    c_oe, m_oe, m_bad;
  logic [`ASRC_DATA_W-1:0] rd_data, c_dat, m_dat, bus, q;
  logic [`ASRC_ADDR_W-1:0] addr;
  int                      mismatches = 0;
  int                      checks_done = 0;
  always #(`ASRC_CLK_NS / 2) core_clk_i = ~core_clk_i;
  // Undriven bus shows the inverse of the memory's word
  assign bus = c_oe ? c_dat : (m_oe ? m_dat : ~m_dat);
  asrc_ctrl dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i),
    .req_we_i(req_we_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .mem_addr_o(addr), .select_active_low_o(sel_n),
    .select_active_high_o(sel), .mem_we_n_o(we_n), .mem_oe_n_o(oe_n),
    .mem_data_i(bus), .mem_data_o(c_dat), .mem_data_oe_o(c_oe));
  asrc_mem_model mem_u (.addr_i(addr), .sel_n_i(sel_n), .sel_i(sel),
    .we_n_i(we_n), .oe_n_i(oe_n), .data_i(bus), .data_o(m_dat),
    .data_oe_o(m_oe), .bad_o(m_bad));
  task automatic cmp_bit(input logic a, input logic e);
    checks_done++;
    if (a !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] a, input logic [7:0] e);
    checks_done++;
    if (a !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  function automatic logic [7:0] walk_pat(input int i);
    if (i < 8) begin
      return 8'h01 << i;
    end else begin
      return ~(8'h01 << (i - 8));
    end
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic xfer(input logic we, input logic [12:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(negedge core_clk_i);
      n++;
    end
    cmp_bit(ready, 1'b1);
    req_i = 1'b1;
    req_we_i = we;
    req_addr_i = a;
    req_wdata_i = d;
    @(negedge core_clk_i);
    req_i = 1'b0;
    n = 0;
    while (!we && rd_valid !== 1'b1 && n < 20) begin
      @(negedge core_clk_i);
      n++;
    end
    if (!we) begin
      cmp_bit(rd_valid, 1'b1);
    end
    q = rd_data;
  endtask
  task automatic t_reset;
    cmp_bit(sel_n, 1'b1);
    cmp_bit(sel, 1'b0);
    cmp_bit(we_n, 1'b1);
    cmp_bit(c_oe, 1'b0);
    cmp_bit(oe_n, 1'b1);
    cmp_bit(ready, 1'b0);
    cmp_bit(rd_valid, 1'b0);
  endtask
  // Walking one over every address line, ones then zeros on data
  task automatic t_walk;
    for (int i = 0; i < `ASRC_ADDR_W; i++) begin
      xfer(1'b1, 13'h0001 << i, walk_pat(i));
    end
    for (int i = 0; i < `ASRC_ADDR_W; i++) begin
      xfer(1'b0, 13'h0001 << i, 8'h00);
      cmp_byte(q, walk_pat(i));
    end
  endtask
  task automatic t_overwrite;
    xfer(1'b1, 13'h1fff, 8'h5a);
    xfer(1'b1, 13'h0abc, 8'h00);
    xfer(1'b1, 13'h0abc, 8'h3c);
    xfer(1'b0, 13'h0abc, 8'h00);
    cmp_byte(q, 8'h3c);
    xfer(1'b0, 13'h1fff, 8'h00);
    cmp_byte(q, 8'h5a);
  endtask
  // Request while busy must be dropped
  task automatic t_busy;
    xfer(1'b1, 13'h0100, 8'h11);
    @(negedge core_clk_i);
    cmp_bit(ready, 1'b0);
    req_i = 1'b1;
    req_wdata_i = 8'h22;
    @(negedge core_clk_i);
    req_i = 1'b0;
    xfer(1'b0, 13'h0100, 8'h00);
    cmp_byte(q, 8'h11);
  endtask
  // Reset cuts a write before its strobe; the old word must survive
  task automatic t_reset_mid;
    xfer(1'b1, 13'h0042, 8'ha5);
    xfer(1'b1, 13'h0042, 8'h3c);
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    t_reset;
    rst_i = 1'b0;
    xfer(1'b0, 13'h0042, 8'h00);
    cmp_byte(q, 8'ha5);
  endtask
  always @(negedge core_clk_i) if (!rst_i) cmp_bit(c_oe & m_oe, 1'b0);
  initial begin
    #(1000 * `ASRC_CLK_NS);
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (10) @(negedge core_clk_i);
    t_reset;
    rst_i = 1'b0;
    t_walk;
    t_overwrite;
    t_busy;
    t_reset_mid;
    cmp_bit(m_bad, 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
